// ==== sctl_pkg.sv ====
// Purpose: constants and types shared by the system control register bank
// Assumes: one 32-bit control word, coprocessor style access fields
// Notes:   fixed-one and writable masks define the reserved bit behaviour
`default_nettype none

package sctl_pkg;

  // primary register numbers and selector values
  localparam logic [3:0] SCTL_CRN_IDENT = 4'h0;
  localparam logic [3:0] SCTL_CRN_CTRL  = 4'h1;
  localparam logic [3:0] SCTL_SEC_ZERO  = 4'h0;
  localparam logic [2:0] SCTL_OP2_CTRL  = 3'h0;
  localparam logic [2:0] SCTL_OP2_TLM   = 3'h2;

  // field positions of the control word
  localparam int SCTL_BIT_MMU     = 0;
  localparam int SCTL_BIT_ALIGN   = 1;
  localparam int SCTL_BIT_DCACHE  = 2;
  localparam int SCTL_BIT_BIGEND  = 7;
  localparam int SCTL_BIT_SYSPROT = 8;
  localparam int SCTL_BIT_ROMPROT = 9;
  localparam int SCTL_BIT_ICACHE  = 12;
  localparam int SCTL_BIT_HIVEC   = 13;
  localparam int SCTL_BIT_RROBIN  = 14;
  localparam int SCTL_BIT_THUMB   = 15;

  // only these bits hold state; the rest are fixed on read
  localparam logic [31:0] SCTL_WRITE_MASK = 32'h0000_f387;
  // bits 18, 16 and 6:3 read as one
  localparam logic [31:0] SCTL_FIXED_ONES = 32'h0005_0078;
  // value of every stored bit after reset, before the two strap bits
  localparam logic [31:0] SCTL_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SCTL_READ_NONE  = 32'h0000_0000;

  // exception vector bases
  localparam logic [31:0] SCTL_VEC_LOW  = 32'h0000_0000;
  localparam logic [31:0] SCTL_VEC_HIGH = 32'hffff_0000;

  // full read image of the control word
  function automatic logic [31:0] sctl_read_word(input logic [31:0] ctrl);
    sctl_read_word = (ctrl & SCTL_WRITE_MASK) | SCTL_FIXED_ONES;
  endfunction

  // both secondary selectors must match for a legal access
  function automatic logic sctl_sel_ok(input logic [3:0] sec,
                                       input logic [2:0] op2,
                                       input logic [2:0] want);
    sctl_sel_ok = (sec == SCTL_SEC_ZERO) && (op2 == want);
  endfunction

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] vec_base;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
  } sctl_state_type;

endpackage

`default_nettype wire

// ==== sctl_dec_if.sv ====
// Purpose: carries an access request to the decoder and its selects back
// Assumes: selects are combinational from the request fields
// Notes:   one request per cycle at most
`timescale 1ns/1ps
`default_nettype none

interface sctl_dec_if;
  logic       req;
  logic       wr;
  logic [3:0] crn;
  logic [3:0] sec_field;
  logic [2:0] op2;
  logic       ctrl_wr;
  logic       ctrl_rd;
  logic       tlm_rd;
  logic       bad;

  modport dec  (input req, wr, crn, sec_field, op2,
                output ctrl_wr, ctrl_rd, tlm_rd, bad);
  modport core (output req, wr, crn, sec_field, op2,
                input ctrl_wr, ctrl_rd, tlm_rd, bad);
endinterface

`default_nettype wire

// ==== sctl_decode.sv ====
// Purpose: decodes a coprocessor access into register selects
// Assumes: request fields are stable in the cycle req is high
// Notes:   anything not decoded raises bad and changes no state
`timescale 1ns/1ps
`default_nettype none

module sctl_decode (
  sctl_dec_if.dec dif
);
  import sctl_pkg::*;

  // address decode as an if chain; bad covers every unmapped access
  always_comb begin
    dif.ctrl_wr = 1'b0;
    dif.ctrl_rd = 1'b0;
    dif.tlm_rd  = 1'b0;
    dif.bad     = 1'b0;
    if (!dif.req) begin
      dif.bad = 1'b0;
    end else if ((dif.crn == SCTL_CRN_CTRL) &&
                 sctl_sel_ok(dif.sec_field, dif.op2, SCTL_OP2_CTRL)) begin
      dif.ctrl_wr = dif.wr;
      dif.ctrl_rd = !dif.wr;
    end else if ((dif.crn == SCTL_CRN_IDENT) && !dif.wr &&
                 sctl_sel_ok(dif.sec_field, dif.op2, SCTL_OP2_TLM)) begin
      dif.tlm_rd = 1'b1;
    end else begin
      dif.bad = 1'b1;
    end
  end

endmodule // sctl_decode

`default_nettype wire

// ==== sctl_ctrl_reg.sv ====
// Purpose: system control register bank of the processor
// Assumes: one access per request pulse, answered on the next edge
// Notes:   reserved upper bits read as zero; id and cache words not held
//
// How it works
// - primary 0, selector 2 returns memory status
// - reset clears all bits but V, B
// - vector bit takes high vector pin
// - endian bit takes big endian pin
// - upper reserved bits unpredictable, write zero
// - bits 18,16 read one, 17 zero
// - bit 15 stops loads setting Thumb
// - bit 14 picks round robin replacement
// - bit 13 moves vectors to high base
// - bit 12 enables instruction cache
// - bit 9 modifies ROM protection
// - bit 8 modifies system protection
// - bit 7 selects big endian
// - bit 2 enables data cache
// - bit 1 enables alignment checking
// - bit 0 enables translation unit
`timescale 1ns/1ps
`default_nettype none

module sctl_ctrl_reg #(
  parameter int DATA_W = 32
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              high_vector_init_pin,
  input  wire logic              big_endian_init_pin,
  input  wire logic              cp_req,
  input  wire logic              cp_write,
  input  wire logic [3:0]        cp_crn,
  input  wire logic [3:0]        cp_secondary_reg_field,
  input  wire logic [2:0]        cp_op2,
  input  wire logic [DATA_W-1:0] cp_wdata,
  input  wire logic [DATA_W-1:0] tight_local_memory_status,
  output var  logic [DATA_W-1:0] cp_rdata,
  output var  logic              cp_ack,
  output var  logic              cp_err,
  output var  logic              mmu_en,
  output var  logic              align_chk_en,
  output var  logic              dcache_en,
  output var  logic              big_endian,
  output var  logic              sys_prot,
  output var  logic              rom_prot,
  output var  logic              icache_en,
  output var  logic              high_vectors,
  output var  logic              round_robin_select,
  output var  logic              thumb_on_pc_load_off,
  output var  logic [31:0]       vector_base
);
  import sctl_pkg::*;

  sctl_state_type st_r;
  sctl_state_type st_nxt;
  sctl_dec_if     dif ();

  // request fields go to the decoder unchanged
  assign dif.req       = cp_req;
  assign dif.wr        = cp_write;
  assign dif.crn       = cp_crn;
  assign dif.sec_field = cp_secondary_reg_field;
  assign dif.op2       = cp_op2;

  sctl_decode u_decode (
    .dif (dif)
  );

  // next state; reset is synchronous so the strap pins may be sampled
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = cp_req;
    st_nxt.err   = dif.bad;
    st_nxt.rdata = SCTL_READ_NONE;
    if (!resetn) begin
      st_nxt.ctrl = SCTL_CTRL_RESET;
      st_nxt.ctrl[SCTL_BIT_HIVEC]  = high_vector_init_pin;
      st_nxt.ctrl[SCTL_BIT_BIGEND] = big_endian_init_pin;
      st_nxt.ack   = 1'b0;
      st_nxt.err   = 1'b0;
    end else begin
      if (dif.ctrl_wr) begin
        // reserved bits are dropped on write, so any value is harmless
        st_nxt.ctrl = cp_wdata[31:0] & SCTL_WRITE_MASK;
      end
      if (dif.ctrl_rd) begin
        st_nxt.rdata = sctl_read_word(st_r.ctrl);
      end else if (dif.tlm_rd) begin
        st_nxt.rdata = tight_local_memory_status[31:0];
      end
    end
    // base follows the stored vector bit, so it changes with it
    st_nxt.vec_base = st_nxt.ctrl[SCTL_BIT_HIVEC] ? SCTL_VEC_HIGH
                                                  : SCTL_VEC_LOW;
  end

  // one register stage holds the whole state
  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  // answer and control outputs straight from the state flops
  assign cp_rdata             = st_r.rdata;
  assign cp_ack               = st_r.ack;
  assign cp_err               = st_r.err;
  assign mmu_en               = st_r.ctrl[SCTL_BIT_MMU];
  assign align_chk_en         = st_r.ctrl[SCTL_BIT_ALIGN];
  assign dcache_en            = st_r.ctrl[SCTL_BIT_DCACHE];
  assign big_endian           = st_r.ctrl[SCTL_BIT_BIGEND];
  assign sys_prot             = st_r.ctrl[SCTL_BIT_SYSPROT];
  assign rom_prot             = st_r.ctrl[SCTL_BIT_ROMPROT];
  assign icache_en            = st_r.ctrl[SCTL_BIT_ICACHE];
  assign high_vectors         = st_r.ctrl[SCTL_BIT_HIVEC];
  assign round_robin_select   = st_r.ctrl[SCTL_BIT_RROBIN];
  assign thumb_on_pc_load_off = st_r.ctrl[SCTL_BIT_THUMB];
  assign vector_base          = st_r.vec_base;

  // ---------------------------------------------------------------
  // checks on the bank, all in the one clock domain
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // after reset only the two strap bits may be set
  reset_clears_a: assert property (
    $past(resetn, 1) == 1'b0 |->
      ((st_r.ctrl & ~((32'h1 << SCTL_BIT_HIVEC) |
                      (32'h1 << SCTL_BIT_BIGEND))) == SCTL_CTRL_RESET))
    else $error("control bits not cleared by reset");

  vec_strap_a: assert property (
    $past(resetn, 1) == 1'b0 |->
      high_vectors == $past(high_vector_init_pin, 1))
    else $error("vector bit does not follow its strap at reset");

  endian_strap_a: assert property (
    $past(resetn, 1) == 1'b0 |->
      big_endian == $past(big_endian_init_pin, 1))
    else $error("endian bit does not follow its strap at reset");

  // status word returned one edge after a legal read of it
  tlm_read_a: assert property (
    (cp_req && !cp_write && cp_crn == SCTL_CRN_IDENT &&
     cp_secondary_reg_field == SCTL_SEC_ZERO && cp_op2 == SCTL_OP2_TLM)
      |=> cp_ack && !cp_err &&
          cp_rdata == $past(tight_local_memory_status, 1))
    else $error("memory status word not returned");

  // nonzero secondary field on the control word is refused
  bad_select_a: assert property (
    (cp_req && cp_crn == SCTL_CRN_CTRL &&
     cp_secondary_reg_field != SCTL_SEC_ZERO)
      |=> cp_err && cp_ack && $stable(st_r.ctrl))
    else $error("bad selector access was not refused");

  // fixed bits on every control read
  fixed_bits_a: assert property (
    (cp_req && dif.ctrl_rd) |=>
      cp_rdata[18:16] == 3'b101 && cp_rdata[31:19] == 13'h0000)
    else $error("reserved bits 18 to 16 read wrongly");

  low_fixed_a: assert property (
    (cp_req && dif.ctrl_rd) |=>
      cp_rdata[11:10] == 2'b00 && cp_rdata[6:3] == 4'hf)
    else $error("reserved bits 11:10 or 6:3 read wrongly");

  // a write reaches the outputs on the next edge and reads back
  write_low_a: assert property (
    dif.ctrl_wr |=> {dcache_en, align_chk_en, mmu_en} ==
      $past(cp_wdata[2:0], 1))
    else $error("cache, alignment or mmu enable not written");

  write_mid_a: assert property (
    dif.ctrl_wr |=>
      {thumb_on_pc_load_off, round_robin_select, high_vectors,
       icache_en, rom_prot, sys_prot, big_endian} ==
      {$past(cp_wdata[15:12], 1), $past(cp_wdata[9:7], 1)})
    else $error("upper control fields not written");

  readback_a: assert property (
    dif.ctrl_wr ##1 (cp_req && dif.ctrl_rd) |=>
      (cp_rdata & SCTL_WRITE_MASK) ==
      ($past(cp_wdata, 2) & SCTL_WRITE_MASK))
    else $error("read after write does not match");

  // vector base tracks the vector bit at all times
  vector_base_a: assert property (
    vector_base == (high_vectors ? SCTL_VEC_HIGH : SCTL_VEC_LOW))
    else $error("vector base out of step with vector bit");

  // upper reserved write data never lands in stored state
  upper_drop_a: assert property (
    dif.ctrl_wr |=> (st_r.ctrl & ~SCTL_WRITE_MASK) == 32'h0000_0000)
    else $error("reserved write bits were stored");

  // every request gets exactly one answer pulse one edge later
  ack_timing_a: assert property (
    cp_req |=> cp_ack)
    else $error("request not answered on the next edge");

  ack_only_a: assert property (
    !cp_req |=> !cp_ack && !cp_err)
    else $error("answer without request");

endmodule // sctl_ctrl_reg

`default_nettype wire

// ==== sctl_ctrl_reg_test.sv ====
// Purpose: self-checking bench for the system control register bank
// Assumes: one request per call, answer sampled 1 ns after the take edge
// Notes:   reserved upper bits are expected as zero, the designer's pick
`timescale 1ns/1ps
`default_nettype none

module sctl_ctrl_reg_test;
  import sctl_pkg::*;

  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        high_vector_init_pin = 1'b0;
  logic        big_endian_init_pin = 1'b0;
  logic        cp_req = 1'b0;
  logic        cp_write = 1'b0;
  logic [3:0]  cp_crn = 4'h0;
  logic [3:0]  cp_secondary_reg_field = 4'h0;
  logic [2:0]  cp_op2 = 3'h0;
  logic [31:0] cp_wdata = 32'h0000_0000;
  logic [31:0] tight_local_memory_status = 32'h0000_0000;
  logic [31:0] cp_rdata;
  logic        cp_ack;
  logic        cp_err;
  logic        mmu_en, align_chk_en, dcache_en, big_endian, sys_prot;
  logic        rom_prot, icache_en, high_vectors;
  logic        round_robin_select, thumb_on_pc_load_off;
  logic [31:0] vector_base;
  logic [9:0]  outs;
  logic [31:0] rd;
  logic        er;
  int          n_errors = 0;
  int          n_tests = 0;
  int          bits [10] = '{0, 1, 2, 7, 8, 9, 12, 13, 14, 15};
  // refused accesses packed as {write, primary, secondary, selector}
  logic [11:0] bad [7] = '{12'h088, 12'h881, 12'h802, 12'h000,
                           12'h01a, 12'h8a0, 12'h280};

  sctl_ctrl_reg sctl_ctrl_reg_inst (
    .core_clk                  (core_clk),
    .resetn                    (resetn),
    .high_vector_init_pin      (high_vector_init_pin),
    .big_endian_init_pin       (big_endian_init_pin),
    .cp_req                    (cp_req),
    .cp_write                  (cp_write),
    .cp_crn                    (cp_crn),
    .cp_secondary_reg_field    (cp_secondary_reg_field),
    .cp_op2                    (cp_op2),
    .cp_wdata                  (cp_wdata),
    .tight_local_memory_status (tight_local_memory_status),
    .cp_rdata                  (cp_rdata),
    .cp_ack                    (cp_ack),
    .cp_err                    (cp_err),
    .mmu_en                    (mmu_en),
    .align_chk_en              (align_chk_en),
    .dcache_en                 (dcache_en),
    .big_endian                (big_endian),
    .sys_prot                  (sys_prot),
    .rom_prot                  (rom_prot),
    .icache_en                 (icache_en),
    .high_vectors              (high_vectors),
    .round_robin_select        (round_robin_select),
    .thumb_on_pc_load_off      (thumb_on_pc_load_off),
    .vector_base               (vector_base)
  );

  // control outputs gathered in control-word bit order, high bit first
  assign outs = {thumb_on_pc_load_off, round_robin_select, high_vectors,
                 icache_en, rom_prot, sys_prot, big_endian, dcache_en,
                 align_chk_en, mmu_en};

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  // read image worked out from the bit table, not from the package helper
  function automatic logic [31:0] img(input logic [31:0] w);
    return (w & 32'h0000_f387) | 32'h0005_0078;
  endfunction

  function automatic logic [9:0] sel(input logic [31:0] w);
    return {w[15], w[14], w[13], w[12], w[9], w[8], w[7], w[2], w[1], w[0]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access: drive after an edge, hold to the take, look at the answer
  task automatic acc(input logic wr, input logic [3:0] crn,
                     input logic [3:0] sec, input logic [2:0] op2,
                     input logic [31:0] wd);
    @(posedge core_clk);
    #1;
    cp_req = 1'b1;
    cp_write = wr;
    cp_crn = crn;
    cp_secondary_reg_field = sec;
    cp_op2 = op2;
    cp_wdata = wd;
    @(posedge core_clk);
    #1;
    cp_req = 1'b0;
    chk("ack", {31'h0, cp_ack}, 32'h1);
    rd = cp_rdata;
    er = cp_err;
  endtask

  // straps are held through the whole reset so either sampling point works
  task automatic rst(input logic hv, input logic be);
    @(posedge core_clk);
    #1;
    resetn = 1'b0;
    high_vector_init_pin = hv;
    big_endian_init_pin = be;
    repeat (3) @(posedge core_clk);
    #1;
    resetn = 1'b1;
  endtask

  // compare pins, vector base and a control read against stored word w
  task automatic state(input logic [31:0] w);
    chk("outs", {22'h0, outs}, {22'h0, sel(w)});
    chk("vector_base", vector_base, w[13] ? 32'hffff_0000 : 32'h0000_0000);
    acc(1'b0, 4'h1, 4'h0, 3'h0, 32'h0000_0000);
    chk("ctrl word", rd, img(w));
    chk("ctrl err", {31'h0, er}, 32'h0);
  endtask

  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 400 cycles
  initial begin
    #20000;
    n_errors++;
    stop_test();
  end

  // main sequence
  initial begin
    rst(1'b1, 1'b1);
    state(32'h0000_2080);
    rst(1'b0, 1'b0);
    state(32'h0000_0000);
    // one control bit at a time, the others must stay clear
    foreach (bits[i]) begin
      acc(1'b1, 4'h1, 4'h0, 3'h0, 32'h1 << bits[i]);
      state(32'h1 << bits[i]);
    end
    acc(1'b1, 4'h1, 4'h0, 3'h0, 32'hffff_ffff);
    state(32'hffff_ffff);
    acc(1'b1, 4'h1, 4'h0, 3'h0, 32'h0000_0000);
    state(32'h0000_0000);
    // memory status read follows the input level
    tight_local_memory_status = 32'h5a5a_1234;
    acc(1'b0, 4'h0, 4'h0, 3'h2, 32'h0000_0000);
    chk("status", rd, 32'h5a5a_1234);
    chk("status err", {31'h0, er}, 32'h0);
    tight_local_memory_status = 32'ha5a5_edcb;
    acc(1'b0, 4'h0, 4'h0, 3'h2, 32'h0000_0000);
    chk("status", rd, 32'ha5a5_edcb);
    // software path: read, modify, write back
    acc(1'b1, 4'h1, 4'h0, 3'h0, 32'h0000_4001);
    acc(1'b0, 4'h1, 4'h0, 3'h0, 32'h0000_0000);
    acc(1'b1, 4'h1, 4'h0, 3'h0, rd | 32'h0000_1000);
    state(32'h0000_5001);
    // refused accesses: error, no data, no change of the stored word
    foreach (bad[i]) begin
      acc(bad[i][11], bad[i][10:7], bad[i][6:3], bad[i][2:0],
          32'hffff_ffff);
      chk("refuse err", {31'h0, er}, 32'h1);
      chk("refuse data", rd, 32'h0000_0000);
      state(32'h0000_5001);
    end
    // back to back: write, then read in the very next cycle
    @(posedge core_clk);
    #1;
    cp_req = 1'b1;
    cp_write = 1'b1;
    cp_crn = 4'h1;
    cp_secondary_reg_field = 4'h0;
    cp_op2 = 3'h0;
    cp_wdata = 32'h0000_a104;
    @(posedge core_clk);
    #1;
    cp_write = 1'b0;
    chk("b2b ack", {31'h0, cp_ack}, 32'h1);
    chk("b2b outs", {22'h0, outs}, {22'h0, sel(32'h0000_a104)});
    @(posedge core_clk);
    #1;
    cp_req = 1'b0;
    chk("b2b ack", {31'h0, cp_ack}, 32'h1);
    chk("b2b word", cp_rdata, img(32'h0000_a104));
    // mid-run reset brings the straps back
    rst(1'b1, 1'b0);
    state(32'h0000_2000);
    rst(1'b0, 1'b1);
    state(32'h0000_0080);
    stop_test();
  end
endmodule // sctl_ctrl_reg_test

`default_nettype wire
